/* File: logic/keyed_watchdog_timer.sv */
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
module keyed_watchdog_timer #(
	parameter int unsigned AW        = 12,
	parameter int unsigned EXP_SHORT = wdt_pkg::EXP_SHORT,
	parameter int unsigned EXP_BASE  = wdt_pkg::EXP_BASE,
	parameter int unsigned EXP_TEST  = wdt_pkg::EXP_TEST
) (
	// Clock and reset
	input  wire logic          ref_clk_in,
	input  wire logic          rstn_in,
	// Wishbone classic slave
	input  wire logic          wb_cyc_in,
	input  wire logic          wb_stb_in,
	input  wire logic          wb_we_in,
	input  wire logic [AW-1:0] wb_adr_in,
	input  wire logic [3:0]    wb_sel_in,
	input  wire logic [31:0]   wb_dat_in,
	output logic      [31:0]   wb_dat_out,
	output logic               wb_ack_out,
	// Timeout events
	output logic               wdt_sys_reset_out,
	output logic               wdt_nmi_out
);

	////////////////////////////////////////////////////////////////////////
	// State
	logic                  ack_q;
	logic                  ack_d;
	logic [31:0]           rdata_q;
	logic [31:0]           rdata_d;
	logic                  on_q;
	logic                  on_d;
	logic                  rst_sel_q;
	logic                  rst_sel_d;
	logic                  test_q;
	logic                  test_d;
	logic [7:0]            count_sel_q;
	logic [7:0]            count_sel_d;
	logic                  rst_seen_q;
	logic                  rst_seen_d;
	logic                  nmi_seen_q;
	logic                  nmi_seen_d;
	logic                  cfg_used_q;
	logic                  cfg_used_d;
	wdt_pkg::key_state_type key_q;
	wdt_pkg::key_state_type key_d;
	logic                  sys_rst_q;
	logic                  sys_rst_d;
	logic                  nmi_q;
	logic                  nmi_d;

	// Decode and strobes
	logic                  access;
	logic                  hit_adr;
	logic                  wr;
	logic                  rd;
	logic [15:0]           wd;
	logic                  is_key;
	logic                  keyed_wr;
	logic                  keyed_rd;
	logic                  restart;
	logic                  rst_event;
	logic                  nmi_event;
	logic [15:0]           ctrl_view;

	wdt_count_if cnt_if ();

	////////////////////////////////////////////////////////////////////////
	// Read view; the running count has no place in it
	always_comb begin
		ctrl_view                       = '0;
		ctrl_view[wdt_pkg::BIT_ON]       = on_q;
		ctrl_view[wdt_pkg::BIT_RST_SEL]  = rst_sel_q;
		ctrl_view[wdt_pkg::BIT_RST_SEEN] = rst_seen_q;
		ctrl_view[wdt_pkg::BIT_NMI_SEEN] = nmi_seen_q;
		ctrl_view[wdt_pkg::BIT_TEST]     = test_q;
		ctrl_view[7:0]                  = count_sel_q;
	end

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	always_comb begin
		access  = wb_cyc_in && wb_stb_in && !ack_q;
		hit_adr = wb_adr_in[AW-1:2] == (AW-2)'(wdt_pkg::WDT_INDEX);
		// Keys need both low byte lanes; a partial write is acked and dropped
		wr      = access && hit_adr && wb_we_in && (wb_sel_in[1:0] == 2'b11);
		rd      = access && hit_adr && !wb_we_in;
		wd      = wb_dat_in[15:0];
		is_key  = (wd == wdt_pkg::KEY_CFG_FIRST) || (wd == wdt_pkg::KEY_CFG_SECOND) ||
			(wd == wdt_pkg::KEY_RST_FIRST) || (wd == wdt_pkg::KEY_RST_SECOND);
	end

	////////////////////////////////////////////////////////////////////////
	// Bus reply; every access is acked once, whatever the address
	always_comb begin
		ack_d   = access;
		rdata_d = rdata_q;
		// Read data is held between accesses, so a slow master still sees it
		if (access) begin
			rdata_d = hit_adr ? {16'h0000, ctrl_view} : 32'h0000_0000;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Key sequencing and configuration
	always_comb begin
		on_d        = on_q;
		rst_sel_d   = rst_sel_q;
		test_d      = test_q;
		count_sel_d = count_sel_q;
		cfg_used_d  = cfg_used_q;
		key_d       = key_q;
		restart     = 1'b0;
		keyed_wr    = 1'b0;
		keyed_rd    = 1'b0;

		// Only accesses to this register, and a watchdog reset, move the sequence
		if (wr) begin
			keyed_wr = is_key || (key_q == wdt_pkg::KEY_CFG_OPEN);
			if (wd == wdt_pkg::KEY_CFG_FIRST) begin
				key_d = wdt_pkg::KEY_CFG_HALF;
			end else if (wd == wdt_pkg::KEY_RST_FIRST) begin
				key_d = wdt_pkg::KEY_RST_HALF;
			end else begin
				key_d = wdt_pkg::KEY_IDLE;
			end
			unique case (key_q)
				wdt_pkg::KEY_IDLE: begin
				end
				wdt_pkg::KEY_CFG_HALF: begin
					// Second half opens only while the one write is unused
					if (wd == wdt_pkg::KEY_CFG_SECOND) begin
						key_d = cfg_used_q ? wdt_pkg::KEY_IDLE : wdt_pkg::KEY_CFG_OPEN;
					end
				end
				wdt_pkg::KEY_CFG_OPEN: begin
					// Whatever is written now is the new configuration
					key_d       = wdt_pkg::KEY_IDLE;
					cfg_used_d  = 1'b1;
					on_d        = wd[wdt_pkg::BIT_ON];
					rst_sel_d   = wd[wdt_pkg::BIT_RST_SEL];
					test_d      = wd[wdt_pkg::BIT_TEST];
					count_sel_d = wd[7:0];
				end
				wdt_pkg::KEY_RST_HALF: begin
					if (wd == wdt_pkg::KEY_RST_SECOND) begin
						restart = 1'b1;
						key_d   = wdt_pkg::KEY_IDLE;
					end
				end
			endcase
		end else if (rd) begin
			// A read while the register is open is a keyed read
			keyed_rd = key_q == wdt_pkg::KEY_CFG_OPEN;
			key_d    = wdt_pkg::KEY_IDLE;
		end

		// A watchdog reset puts the configuration back to its reset state
		if (rst_event) begin
			on_d        = wdt_pkg::CTRL_RESET[wdt_pkg::BIT_ON];
			rst_sel_d   = wdt_pkg::CTRL_RESET[wdt_pkg::BIT_RST_SEL];
			test_d      = wdt_pkg::CTRL_RESET[wdt_pkg::BIT_TEST];
			count_sel_d = wdt_pkg::COUNT_RESET;
			// The one configuration write is allowed again, as after power-up
			cfg_used_d  = 1'b0;
			key_d       = wdt_pkg::KEY_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers; reset values give c080
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			on_q        <= wdt_pkg::CTRL_RESET[wdt_pkg::BIT_ON];
			rst_sel_q   <= wdt_pkg::CTRL_RESET[wdt_pkg::BIT_RST_SEL];
			test_q      <= wdt_pkg::CTRL_RESET[wdt_pkg::BIT_TEST];
			count_sel_q <= wdt_pkg::COUNT_RESET;
			cfg_used_q  <= 1'b0;
			key_q       <= wdt_pkg::KEY_IDLE;
		end else begin
			on_q        <= on_d;
			rst_sel_q   <= rst_sel_d;
			test_q      <= test_d;
			count_sel_q <= count_sel_d;
			cfg_used_q  <= cfg_used_d;
			key_q       <= key_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status flags; an event in the same cycle beats the clearing access
	always_comb begin
		rst_seen_d = rst_seen_q;
		nmi_seen_d = nmi_seen_q;
		if (keyed_wr || keyed_rd) begin
			rst_seen_d = 1'b0;
		end
		if (keyed_wr) begin
			nmi_seen_d = 1'b0;
		end
		if (nmi_event) begin
			nmi_seen_d = 1'b1;
		end
		// A watchdog reset leaves only its own flag standing
		if (rst_event) begin
			rst_seen_d = 1'b1;
			nmi_seen_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_seen_q <= 1'b0;
			nmi_seen_q <= 1'b0;
		end else begin
			rst_seen_q <= rst_seen_d;
			nmi_seen_q <= nmi_seen_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timeout events; the NMI flag left set escalates to reset
	always_comb begin
		rst_event = 1'b0;
		nmi_event = 1'b0;
		if (cnt_if.expired && on_q) begin
			if (rst_sel_q || nmi_seen_q) begin
				rst_event = 1'b1;
			end else begin
				nmi_event = 1'b1;
			end
		end
		sys_rst_d = rst_event;
		nmi_d     = nmi_event;
	end

	// Pulses leave from flops, so the reset line cannot glitch
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sys_rst_q <= 1'b0;
			nmi_q     <= 1'b0;
		end else begin
			sys_rst_q <= sys_rst_d;
			nmi_q     <= nmi_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counter hookup
	assign cnt_if.run       = on_q;
	// A reset event also restarts the count, as a system reset would
	assign cnt_if.restart   = restart || rst_event;
	assign cnt_if.count_sel = count_sel_q;
	assign cnt_if.test      = test_q;

	wdt_counter #(
		.CW        (wdt_pkg::COUNT_WIDTH),
		.EXP_SHORT (EXP_SHORT),
		.EXP_BASE  (EXP_BASE),
		.EXP_TEST  (EXP_TEST)
	) u_counter (
		.ref_clk_in (ref_clk_in),
		.rstn_in    (rstn_in),
		.cnt_if     (cnt_if)
	);

	assign wb_ack_out        = ack_q;
	assign wb_dat_out        = rdata_q;
	assign wdt_sys_reset_out = sys_rst_q;
	assign wdt_nmi_out       = nmi_q;

endmodule : keyed_watchdog_timer

/* File: logic/wdt_pkg.sv */
package wdt_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register placement: printed offset is a register index, not bytes
	localparam logic [7:0]  WDT_INDEX     = 8'he6;
	localparam logic [11:0] WDT_BYTE_ADDR = 12'h398;

	////////////////////////////////////////////////////////////////////////
	// Key words
	localparam logic [15:0] KEY_CFG_FIRST  = 16'h3333;
	localparam logic [15:0] KEY_CFG_SECOND = 16'hcccc;
	localparam logic [15:0] KEY_RST_FIRST  = 16'haaaa;
	localparam logic [15:0] KEY_RST_SECOND = 16'h5555;

	////////////////////////////////////////////////////////////////////////
	// Field positions and values after reset
	localparam int unsigned BIT_ON        = 15;
	localparam int unsigned BIT_RST_SEL   = 14;
	localparam int unsigned BIT_RST_SEEN  = 13;
	localparam int unsigned BIT_NMI_SEEN  = 12;
	localparam int unsigned BIT_TEST      = 11;
	localparam logic [15:0] CTRL_RESET    = 16'hc080;
	localparam logic [7:0]  COUNT_RESET   = 8'h80;

	////////////////////////////////////////////////////////////////////////
	// Timeout exponents
	localparam int unsigned EXP_SHORT     = 10;
	localparam int unsigned EXP_BASE      = 20;
	localparam int unsigned EXP_TEST      = 4;
	localparam int unsigned COUNT_WIDTH   = 27;

	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_CFG_HALF,
		KEY_CFG_OPEN,
		KEY_RST_HALF
	} key_state_type;

endpackage : wdt_pkg

/* File: logic/wdt_count_if.sv */
`timescale 1ns/100ps
interface wdt_count_if;
	logic       run;
	logic       restart;
	logic [7:0] count_sel;
	logic       test;
	logic       expired;

	modport ctrl (output run, output restart, output count_sel, output test, input expired);
	modport cnt  (input run, input restart, input count_sel, input test, output expired);
endinterface : wdt_count_if

/* File: logic/wdt_counter.sv */
`timescale 1ns/100ps
module wdt_counter #(
	parameter int unsigned CW        = wdt_pkg::COUNT_WIDTH,
	parameter int unsigned EXP_SHORT = wdt_pkg::EXP_SHORT,
	parameter int unsigned EXP_BASE  = wdt_pkg::EXP_BASE,
	parameter int unsigned EXP_TEST  = wdt_pkg::EXP_TEST
) (
	// Clock and reset
	input wire logic  ref_clk_in,
	input wire logic  rstn_in,
	// Control side
	wdt_count_if.cnt  cnt_if
);

	logic [CW-1:0] count_q;
	logic [CW-1:0] count_d;
	logic          expired_q;
	logic          expired_d;
	logic [CW-1:0] target;
	int unsigned   exp_sel;
	logic          found;
	logic          hit;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		exp_sel = EXP_SHORT;
		found   = 1'b0;
		// Lowest set bit wins, giving the shortest timeout
		for (int i = 0; i < 8; i++) begin
			if (cnt_if.count_sel[i] && !found) begin
				found   = 1'b1;
				exp_sel = (i == 0) ? EXP_SHORT : EXP_BASE + i - 1;
			end
		end
		// Test mode only ever shortens the interval
		if (cnt_if.test && EXP_TEST < exp_sel) begin
			exp_sel = EXP_TEST;
		end
		target = (CW'(1) << exp_sel) - CW'(1);
		// Empty field has no exponent, so no timeout at all
		hit = cnt_if.run && found && (count_q == target);
		if (cnt_if.restart || !cnt_if.run || hit) begin
			count_d = '0;
		end else begin
			count_d = count_q + CW'(1);
		end
		expired_d = hit && !cnt_if.restart;
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			count_q   <= '0;
			expired_q <= 1'b0;
		end else begin
			count_q   <= count_d;
			expired_q <= expired_d;
		end
	end

	assign cnt_if.expired = expired_q;

endmodule : wdt_counter

/* File: verification/wdt_chk.sv */
`timescale 1ns/100ps
module wdt_chk #(
	parameter int unsigned AW = 12
) (
	// Clock, reset and bus
	input wire logic          ref_clk_in,
	input wire logic          rstn_in,
	input wire logic          wb_cyc_in,
	input wire logic          wb_stb_in,
	input wire logic          wb_we_in,
	input wire logic [AW-1:0] wb_adr_in,
	input wire logic [3:0]    wb_sel_in,
	input wire logic [31:0]   wb_dat_in,
	input wire logic [31:0]   wb_dat_out,
	input wire logic          wb_ack_out,
	// Timeout events
	input wire logic          wdt_sys_reset_out,
	input wire logic          wdt_nmi_out
);
	logic take;
	logic ev;
	logic reg_rd_q;
	logic unm_rd_q;
	assign take = wb_cyc_in && wb_stb_in && !wb_ack_out;
	assign ev   = wdt_sys_reset_out || wdt_nmi_out;
	// Remember what kind of read was taken so its data can be judged with the ack
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			reg_rd_q <= 1'b0;
			unm_rd_q <= 1'b0;
		end else begin
			reg_rd_q <= take && !wb_we_in && wb_adr_in[11:2] == wdt_pkg::WDT_BYTE_ADDR[11:2];
			unm_rd_q <= take && !wb_we_in && wb_adr_in[11:2] != wdt_pkg::WDT_BYTE_ADDR[11:2];
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);
	property p_ack_take; take |=> wb_ack_out; endproperty
	a_ack_take: assert property (p_ack_take) else $error("request not acked next cycle");
	property p_ack_once; wb_ack_out |=> !wb_ack_out; endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
	property p_no_stray; !(wb_cyc_in && wb_stb_in) |=> !wb_ack_out; endproperty
	a_no_stray: assert property (p_no_stray) else $error("ack without request");
	property p_ev_gap; ev |=> !ev [*3]; endproperty
	a_ev_gap: assert property (p_ev_gap) else $error("timeout events too close");
	property p_one_ev; !(wdt_sys_reset_out && wdt_nmi_out); endproperty
	a_one_ev: assert property (p_one_ev) else $error("reset and interrupt together");
	property p_reg_read; reg_rd_q |-> wb_ack_out && wb_dat_out[31:16] == 16'h0 && wb_dat_out[10:8] == 3'h0; endproperty
	a_reg_read: assert property (p_reg_read) else $error("register read shows stray bits");
	property p_unm_read; unm_rd_q |-> wb_ack_out && wb_dat_out == 32'h0; endproperty
	a_unm_read: assert property (p_unm_read) else $error("unmapped read not zero");
	property p_quiet_start; $rose(rstn_in) |-> !ev [*8]; endproperty
	a_quiet_start: assert property (p_quiet_start) else $error("event right after reset");
	c_nmi: cover property (wdt_nmi_out);
	c_sys: cover property (wdt_sys_reset_out);
	c_unm: cover property (unm_rd_q);
endmodule : wdt_chk

bind keyed_watchdog_timer wdt_chk #(.AW(AW)) u_chk (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
	.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
	.wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
	.wdt_sys_reset_out(wdt_sys_reset_out), .wdt_nmi_out(wdt_nmi_out));

/* File: verification/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
	localparam logic [11:0] RA = wdt_pkg::WDT_BYTE_ADDR;
	localparam logic [11:0] UA = 12'h390;
	logic        ref_clk = 1'b0;
	logic        rstn    = 1'b0;
	logic        cyc     = 1'b0;
	logic        stb     = 1'b0;
	logic        we      = 1'b0;
	logic [11:0] adr     = 12'h000;
	logic [31:0] wdat    = 32'h0;
	logic [31:0] rdat;
	logic [31:0] wb_dat_out;
	logic        wb_ack_out;
	logic        sys_rst;
	logic        nmi;
	int          n_mismatch = 0;
	int          tests_run  = 0;
	int          n;
	always #5 ref_clk = ~ref_clk;
	// Short exponents keep the longest timeout near four thousand cycles
	keyed_watchdog_timer #(.AW(12), .EXP_SHORT(3), .EXP_BASE(6), .EXP_TEST(2)) uut (.ref_clk_in(ref_clk),
		.rstn_in(rstn), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
		.wb_dat_in(wdat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .wdt_sys_reset_out(sys_rst),
		.wdt_nmi_out(nmi));
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task bus(input logic w, input logic [11:0] a, input logic [15:0] d);
		int k;
		@(posedge ref_clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= {16'h0, d};
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (wb_ack_out !== 1'b1 && k < 50);
		if (wb_ack_out !== 1'b1) begin
			n_mismatch++;
		end
		rdat = wb_dat_out;
		cyc  <= 1'b0;
		stb  <= 1'b0;
	endtask : bus
	task wr(input logic [11:0] a, input logic [15:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task rd(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 16'h0);
		chk(rdat, e);
	endtask : rd
	task unlock;
		wr(RA, wdt_pkg::KEY_CFG_FIRST);
		wr(RA, wdt_pkg::KEY_CFG_SECOND);
	endtask : unlock
	// A foreign write between the halves must not break the key
	task restart;
		wr(RA, wdt_pkg::KEY_RST_FIRST);
		wr(UA, 16'h1234);
		wr(RA, wdt_pkg::KEY_RST_SECOND);
	endtask : restart
	task ev_wait(input logic want_nmi, input int lim);
		n = 0;
		while (n < lim && (want_nmi ? nmi : sys_rst) !== 1'b1) begin
			@(posedge ref_clk);
			n++;
		end
	endtask : ev_wait
	task hard_reset;
		@(posedge ref_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
	endtask : hard_reset
	////////////////////////////////////////////////////////////////////////
	task sc_config_once;
		wr(RA, wdt_pkg::KEY_CFG_FIRST);
		rd(UA, 32'h0);
		wr(RA, wdt_pkg::KEY_CFG_SECOND);
		wr(UA, 16'hffff);
		wr(RA, 16'hc040);
		rd(RA, 32'hc040);
		unlock();
		wr(RA, 16'h8001);
		rd(RA, 32'hc040);
	endtask : sc_config_once
	task sc_restart;
		restart();
		ev_wait(1'b0, 3000);
		chk(32'(n >= 2046 && n <= 2054), 32'h1);
		rd(RA, 32'he080);
	endtask : sc_restart
	// Restart first so the short period starts from a low count
	task sc_nmi_chain;
		restart();
		unlock();
		wr(RA, 16'h8006);
		rd(RA, 32'h8006);
		ev_wait(1'b1, 80);
		chk(32'(n >= 30 && n <= 64), 32'h1);
		rd(RA, 32'h9006);
		ev_wait(1'b0, 80);
		chk(32'(n >= 50 && n <= 70), 32'h1);
		rd(RA, 32'he080);
	endtask : sc_nmi_chain
	task sc_quiet(input logic [15:0] cfg);
		hard_reset();
		rd(RA, 32'hc080);
		unlock();
		wr(RA, cfg);
		ev_wait(1'b0, 200);
		chk(32'(n), 32'd200);
	endtask : sc_quiet
	// Test mode pulls the shortest interval in from 2^3 to 2^2 cycles
	task sc_test_mode;
		hard_reset();
		unlock();
		wr(RA, 16'hc801);
		restart();
		ev_wait(1'b0, 40);
		chk(32'(n >= 4 && n <= 6), 32'h1);
		rd(RA, 32'he080);
	endtask : sc_test_mode
	task close_out;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		n_mismatch++;
		close_out();
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		rd(RA, {16'h0, wdt_pkg::CTRL_RESET});
		rd(UA, 32'h0);
		sc_config_once();
		sc_restart();
		sc_nmi_chain();
		sc_quiet(16'h4001);
		sc_quiet(16'hc000);
		sc_test_mode();
		close_out();
	end
endmodule : tb_top
